//--- rtl/cocp_pkg.sv
// Package: constants, register map and carrier types for the comparator/OCP control block
//
// Summary of operation
// - Input mode 00 single, 01 dual, 1X three-input routing of the overcurrent comparator.
// - Overcurrent comparator works only when enabled; hysteresis bit is independent.
// - Protection mode 01: event clears drive enable and raises overcurrent request.
// - Protection mode 00: drive enable untouched, overcurrent request still raised.
// - Nonzero mode with external select: source is external irq zero on chosen edge.
// - External select 0 and irq mode 11: event on comparator rising edge.
// - Filter codes 01/10/11 give 6/12/24 cycle width and equal delay.
// - Mode 10: outputs off; restore at timer wrap or after 10 us.
// - Mode 11: outputs off; restore at timer wrap or after 5 us.
// - With external select 0, irq mode 11 makes each comparator rising edge an event; drive enable is cleared only in nonzero protection mode.
// - Bus comparator readable, can drive irq zero, disables outputs through irq zero with external select and nonzero mode.
// - Bus comparator runs when enabled; source 111 routes it to irq zero.
// - Group mode 00: shared external negative pin, separate positives, three outputs.
// - Group mode 01: negatives tied to internal neutral resistor centre.
// - Switch bit 0 default positives, 1 alternate positives for second and third.
// - Group mode 10: each comparator has own differential pair.
// - Group mode 11: only first two active, sharing one negative pin.
// - Member select 00 all, 01 first, 10 second, 11 third; 11 reserved in two-mode.
// - Group outputs pass filtering and sampling before the capture timer.
// - Window opens on-delay after PWM edge, closes on-delay minus off-lead after fall.
// - Sampling select 00 bypasses sampling.
// - Output select routes one comparator to debug pin; switch bit gates second comparator to alternate pin.
// - Irq mode 00 none, 01 rising, 10 falling.
package cocp_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] GROUP_OFS = 8'h04;
  localparam logic [7:0] SAMPLE_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0C;

  // CTRL fields
  localparam int IRQ_MODE_POS = 0;
  localparam int INPUT_MODE_POS = 2;
  localparam int OCP_EN_POS = 4;
  localparam int HYS_POS = 5;
  localparam int PROT_MODE_POS = 6;
  localparam int EXT_SEL_POS = 8;
  localparam int FILT_POS = 9;
  localparam int BUS_EN_POS = 11;
  localparam int SRC_POS = 12;
  localparam int EDGE_POS = 15;
  localparam int REARM_POS = 16;
  // GROUP fields
  localparam int GMODE_POS = 0;
  localparam int GSEL_POS = 2;
  localparam int GSW_POS = 4;
  localparam int GIM_POS = 5;
  localparam int DBG_POS = 8;
  // SAMPLE fields
  localparam int ON_POS = 0;
  localparam int OFF_POS = 8;
  localparam int SAMPLING_SELECT_POS = 16;

  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] GROUP_RST = 32'h0000_0000;
  localparam logic [31:0] SAMPLE_RST = 32'h0000_0000;
  localparam logic [2:0] SRC_BUS = 3'h7;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ = 20;
  localparam int RESTORE_LONG_US = 10;
  localparam int RESTORE_SHORT_US = 5;
  localparam logic [7:0] RESTORE_LONG_CYC = 8'(RESTORE_LONG_US * CLK_MHZ);
  localparam logic [7:0] RESTORE_SHORT_CYC = 8'(RESTORE_SHORT_US * CLK_MHZ);
  localparam logic [4:0] FILT_W1 = 5'h06;
  localparam logic [4:0] FILT_W2 = 5'h0C;
  localparam logic [4:0] FILT_W3 = 5'h18;

  typedef struct packed {
    logic ext_irq_zero_edge;
    logic [2:0] ext_irq_zero_source;
    logic bus_comparator_enable;
    logic [1:0] event_filter_width;
    logic ext_irq_protect_select;
    logic [1:0] protection_mode;
    logic ocp_hysteresis_select;
    logic ocp_comparator_enable;
    logic [1:0] ocp_input_mode;
    logic [1:0] ocp_irq_mode;
  } cocp_ctrl_t;

  typedef struct packed {
    logic group_out_c;
    logic group_out_b;
    logic group_out_a;
  } cocp_group_t;

endpackage

//--- rtl/cocp_sync_filter.sv
// Two-stage synchroniser followed by a programmable width glitch filter
`timescale 1ns/1ps
module cocp_sync_filter (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic async_in,
  input wire logic [1:0] width_code,
  output logic sync_out,
  output logic filt_out
);
  logic meta;
  logic [4:0] cnt;
  logic [4:0] width;
  logic filt_q;

  // Two flops; only the second is observed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

  always_comb begin
    case (width_code)
      2'h1: width = cocp_pkg::FILT_W1;
      2'h2: width = cocp_pkg::FILT_W2;
      2'h3: width = cocp_pkg::FILT_W3;
      default: width = 5'h00;
    endcase
  end

  // Bypass is direct, so a set width adds exactly that many cycles of lag
  assign filt_out = (width == 5'h00) ? sync_out : filt_q;

  // Output follows input only once it held steady for the width; so it lags by width
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 5'h00;
      filt_q <= 1'b0;
    end else if (width == 5'h00 || sync_out == filt_q) begin
      cnt <= 5'h00;
      if (width == 5'h00) filt_q <= sync_out;
    end else if (cnt + 5'h01 >= width) begin
      cnt <= 5'h00;
      filt_q <= sync_out;
    end else begin
      cnt <= cnt + 5'h01;
    end
  end

  a_filter_steady: assert property (@(posedge hclk) disable iff (!hresetn)
    (width_code == 2'h1 && $changed(filt_out)) |-> $past(sync_out, 6) == filt_out)
    else $error("filter released before six steady cycles");
endmodule

//--- rtl/cocp_sampler.sv
// PWM-aligned sampling window: opens after on-delay, closes on-delay minus off-lead after fall
`timescale 1ns/1ps
module cocp_sampler (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pwm,
  input wire logic [7:0] on_delay,
  input wire logic [7:0] off_lead,
  input wire logic [1:0] sel,
  input wire logic [2:0] cmp_in,
  output logic window,
  output logic [2:0] cmp_out
);
  logic pwm_d;
  logic [7:0] on_cnt;
  logic [7:0] off_cnt;
  logic on_run;
  logic off_run;
  logic [7:0] off_target;

  // Negative difference is clamped so the window closes right at the fall
  assign off_target = (on_delay > off_lead) ? 8'(on_delay - off_lead) : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pwm_d <= 1'b0;
    else pwm_d <= pwm;
  end

  // Open timer from rising PWM edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      on_cnt <= 8'h00;
      on_run <= 1'b0;
    end else if (pwm && !pwm_d) begin
      on_cnt <= 8'h00;
      on_run <= 1'b1;
    end else if (on_run) begin
      if (on_cnt >= on_delay) on_run <= 1'b0;
      else on_cnt <= on_cnt + 8'h01;
    end
  end

  // Close timer from falling PWM edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      off_cnt <= 8'h00;
      off_run <= 1'b0;
    end else if (!pwm && pwm_d) begin
      off_cnt <= 8'h00;
      off_run <= 1'b1;
    end else if (off_run) begin
      if (off_cnt >= off_target) off_run <= 1'b0;
      else off_cnt <= off_cnt + 8'h01;
    end
  end

  // Window state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) window <= 1'b0;
    else if (on_run && on_cnt >= on_delay) window <= 1'b1;
    else if (off_run && off_cnt >= off_target) window <= 1'b0;
  end

  // Hold outputs outside the window; bypass when sampling disabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cmp_out <= 3'h0;
    else if (sel == 2'h0 || window) cmp_out <= cmp_in;
  end

  a_bypass_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    (sel == 2'h0) ##1 (sel == 2'h0) |-> cmp_out == $past(cmp_in))
    else $error("sampling bypass did not pass comparator");
endmodule

//--- rtl/cocp_top.sv
// Comparator overcurrent protection, group routing, sampling and debug output control
`timescale 1ns/1ps
module cocp_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ocp_comparator_out,
  input wire logic bus_comparator_out,
  input wire logic [2:0] group_raw,
  input wire logic ext_irq_zero_pin,
  input wire logic pwm,
  input wire logic timer_wrap,
  output logic ocp_comparator_on,
  output logic ocp_hysteresis_on,
  output logic [1:0] ocp_input_mode,
  output logic bus_comparator_on,
  output logic [2:0] group_enable,
  output logic group_neg_shared_pin,
  output logic group_neg_neutral,
  output logic group_neg_separate,
  output logic group_pos_alternate,
  output logic drive_output_enable,
  output logic ocp_request,
  output logic ext_irq_zero,
  output logic [2:0] capture_out,
  output logic debug_pin,
  output logic alternate_pin
);
  // ************************************************************
  // Registers and bus slave
  // ************************************************************
  logic [31:0] ctrl_reg;
  logic [31:0] group_reg;
  logic [31:0] sample_reg;
  cocp_pkg::cocp_ctrl_t ctrl;
  logic ap_valid;
  logic dp_write;
  logic dp_read;
  logic [7:0] dp_addr;
  logic ocp_flag;
  logic rearm_pulse;

  assign ctrl = cocp_pkg::cocp_ctrl_t'(ctrl_reg[15:0]);
  assign ap_valid = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Capture address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready) begin
      dp_write <= ap_valid && hwrite;
      dp_read <= ap_valid && !hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  // Write data phase; rearm bit is a self-clearing strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= cocp_pkg::CTRL_RST;
      group_reg <= cocp_pkg::GROUP_RST;
      sample_reg <= cocp_pkg::SAMPLE_RST;
      rearm_pulse <= 1'b0;
    end else begin
      rearm_pulse <= 1'b0;
      if (dp_write) begin
        case (dp_addr)
          cocp_pkg::CTRL_OFS: begin
            ctrl_reg <= {16'h0000, hwdata[15:0]};
            rearm_pulse <= hwdata[cocp_pkg::REARM_POS];
          end
          cocp_pkg::GROUP_OFS: group_reg <= {22'h0, hwdata[9:0]};
          cocp_pkg::SAMPLE_OFS: sample_reg <= {14'h0, hwdata[17:0]};
          default: ;
        endcase
      end
    end
  end

  logic [2:0] group_sync;
  logic ocp_sync;
  logic bus_sync;
  logic ocp_filt;
  logic [2:0] group_filt;
  logic window;

  // Read data decoded combinationally from the data phase address; unmapped reads zero
  always_comb begin
    case (dp_addr)
      cocp_pkg::CTRL_OFS: hrdata = ctrl_reg;
      cocp_pkg::GROUP_OFS: hrdata = group_reg;
      cocp_pkg::SAMPLE_OFS: hrdata = sample_reg;
      cocp_pkg::STATUS_OFS: hrdata = {24'h0, window, group_sync, ocp_flag,
        drive_output_enable, bus_sync, ocp_sync};
      default: hrdata = 32'h0;
    endcase
    if (!dp_read) hrdata = 32'h0;
  end

  // ************************************************************
  // Synchronisation and filtering
  // ************************************************************
  cocp_sync_filter u_ocp_sf (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(ocp_comparator_out & ctrl.ocp_comparator_enable),
    .width_code(ctrl.event_filter_width),
    .sync_out(ocp_sync),
    .filt_out(ocp_filt)
  );

  cocp_sync_filter u_bus_sf (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(bus_comparator_out & ctrl.bus_comparator_enable),
    .width_code(2'h0),
    .sync_out(bus_sync),
    .filt_out()
  );

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_grp
      cocp_sync_filter u_grp_sf (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(group_raw[gi] & group_enable[gi]),
        .width_code(ctrl.event_filter_width),
        .sync_out(group_sync[gi]),
        .filt_out(group_filt[gi])
      );
    end
  endgenerate

  // ************************************************************
  // Group routing
  // ************************************************************
  logic [1:0] group_mode;
  logic [1:0] group_member_select;
  logic group_input_switch;
  assign group_mode = group_reg[cocp_pkg::GMODE_POS +: 2];
  assign group_member_select = group_reg[cocp_pkg::GSEL_POS +: 2];
  assign group_input_switch = group_reg[cocp_pkg::GSW_POS];

  // Member decode, also used to gate the debug pin choice
  function automatic logic [2:0] member_mask(input logic [1:0] mode, input logic [1:0] sel);
    logic [2:0] m;
    case (sel)
      2'h0: m = 3'h7;
      2'h1: m = 3'h1;
      2'h2: m = 3'h2;
      default: m = 3'h4;
    endcase
    if (mode == 2'h3) m = (sel == 2'h3) ? 3'h0 : (m & 3'h3);
    return m;
  endfunction

  assign group_enable = member_mask(group_mode, group_member_select);
  assign group_neg_shared_pin = (group_mode == 2'h0) || (group_mode == 2'h3);
  assign group_neg_neutral = (group_mode == 2'h1);
  assign group_neg_separate = (group_mode == 2'h2);
  // Speed mode always uses the alternate pin for the second comparator
  assign group_pos_alternate = (group_neg_neutral && group_input_switch) ||
    (group_mode == 2'h3);

  // Overcurrent comparator and bus comparator analogue controls
  assign ocp_comparator_on = ctrl.ocp_comparator_enable;
  assign ocp_hysteresis_on = ctrl.ocp_hysteresis_select;
  assign ocp_input_mode = ctrl.ocp_input_mode[1] ? 2'h2 : ctrl.ocp_input_mode;
  assign bus_comparator_on = ctrl.bus_comparator_enable;

  // ************************************************************
  // Sampling
  // ************************************************************
  cocp_sampler u_samp (
    .hclk(hclk),
    .hresetn(hresetn),
    .pwm(pwm),
    .on_delay(sample_reg[cocp_pkg::ON_POS +: 8]),
    .off_lead(sample_reg[cocp_pkg::OFF_POS +: 8]),
    .sel(sample_reg[cocp_pkg::SAMPLING_SELECT_POS +: 2]),
    .cmp_in(group_filt),
    .window(window),
    .cmp_out(capture_out)
  );

  // ************************************************************
  // External interrupt zero and overcurrent event
  // ************************************************************
  logic irq0_src;
  logic irq0_d;
  logic ocp_d;
  logic irq0_edge;
  logic ocp_rise;
  logic ocp_fall;
  logic ocp_event;

  // Bus comparator takes irq zero only on source 111
  assign irq0_src = (ctrl.ext_irq_zero_source == cocp_pkg::SRC_BUS) ? bus_sync :
    ext_irq_zero_pin;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq0_d <= 1'b0;
      ocp_d <= 1'b0;
    end else begin
      irq0_d <= irq0_src;
      ocp_d <= ocp_filt;
    end
  end

  // Edge bit 1 falling, 0 rising
  assign irq0_edge = ctrl.ext_irq_zero_edge ? (irq0_d && !irq0_src) : (!irq0_d && irq0_src);
  assign ocp_rise = ocp_filt && !ocp_d;
  assign ocp_fall = !ocp_filt && ocp_d;

  // Source choice between irq zero and comparator rising edge
  always_comb begin
    if (ctrl.ext_irq_protect_select && ctrl.protection_mode != 2'h0) ocp_event = irq0_edge;
    else if (!ctrl.ext_irq_protect_select && ctrl.ocp_irq_mode == 2'h3)
      ocp_event = ocp_rise;
    else ocp_event = 1'b0;
  end

  // Irq request: protection event, or plain edge interrupts of the comparator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ocp_request <= 1'b0;
    else ocp_request <= ocp_event ||
      (ctrl.ocp_irq_mode == 2'h1 && ocp_rise) ||
      (ctrl.ocp_irq_mode == 2'h2 && ocp_fall);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ext_irq_zero <= 1'b0;
    else ext_irq_zero <= irq0_edge;
  end

  // Sticky flag; an event in the clear cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ocp_flag <= 1'b0;
    else if (ocp_event) ocp_flag <= 1'b1;
    else if (rearm_pulse) ocp_flag <= 1'b0;
  end

  // ************************************************************
  // Drive output enable and automatic restore
  // ************************************************************
  typedef enum logic [1:0] {COCP_RUN, COCP_TRIP, COCP_WAIT} cocp_state_t;
  cocp_state_t state;
  cocp_state_t next_state;
  logic [7:0] restore_cnt;
  logic [7:0] restore_lim;

  assign restore_lim = (ctrl.protection_mode == 2'h3) ? cocp_pkg::RESTORE_SHORT_CYC :
    cocp_pkg::RESTORE_LONG_CYC;

  // Bus comparator reaches drive enable only through irq zero; mode 01 needs a software rearm
  always_comb begin
    next_state = state;
    case (state)
      COCP_RUN: begin
        if (ocp_event && ctrl.protection_mode == 2'h1) next_state = COCP_TRIP;
        else if (ocp_event && ctrl.protection_mode[1]) next_state = COCP_WAIT;
      end
      COCP_TRIP: if (rearm_pulse && !ocp_event) next_state = COCP_RUN;
      COCP_WAIT: begin
        if (ctrl.protection_mode != 2'h1 && !ctrl.protection_mode[1]) next_state = COCP_RUN;
        else if (timer_wrap || restore_cnt + 8'h01 >= restore_lim) next_state = COCP_RUN;
      end
      default: next_state = COCP_RUN;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) state <= COCP_RUN;
    else state <= next_state;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) restore_cnt <= 8'h00;
    else if (state != COCP_WAIT) restore_cnt <= 8'h00;
    else restore_cnt <= restore_cnt + 8'h01;
  end

  assign drive_output_enable = (state == COCP_RUN);

  // ************************************************************
  // Debug output
  // ************************************************************
  logic [1:0] debug_output_select;
  assign debug_output_select = group_reg[cocp_pkg::DBG_POS +: 2];

  // Code 3 shows the overcurrent comparator; others a group member
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      debug_pin <= 1'b0;
      alternate_pin <= 1'b0;
    end else begin
      debug_pin <= (debug_output_select == 2'h3) ? ocp_sync :
        group_sync[debug_output_select];
      alternate_pin <= group_input_switch & group_sync[1];
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_trip_clears_moe: assert property (@(posedge hclk) disable iff (!hresetn)
    (ocp_event && state == COCP_RUN && ctrl.protection_mode == 2'h1) |=> !drive_output_enable)
    else $error("mode 01 event did not clear drive enable");
  a_mode0_keeps: assert property (@(posedge hclk) disable iff (!hresetn)
    (ocp_event && ctrl.protection_mode == 2'h0 && drive_output_enable)
    |=> drive_output_enable && ocp_request)
    else $error("mode 00 event changed drive enable or lost request");
  a_rise_source: assert property (@(posedge hclk) disable iff (!hresetn)
    (!ctrl.ext_irq_protect_select && ctrl.ocp_irq_mode == 2'h3 && ocp_rise) |-> ocp_event)
    else $error("comparator rising edge missed as event");
  a_ext_source: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl.ext_irq_protect_select && ctrl.protection_mode != 2'h0) |-> ocp_event == irq0_edge)
    else $error("irq zero not used as overcurrent source");
  a_restore_short: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == COCP_RUN && ocp_event && ctrl.protection_mode == 2'h3)
    ##1 (!timer_wrap && ctrl.protection_mode == 2'h3) [*8] |-> !drive_output_enable)
    else $error("mode 11 restored too early");
  a_restore_long: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == COCP_WAIT && restore_cnt == 8'(cocp_pkg::RESTORE_LONG_CYC - 8'h01)
    && ctrl.protection_mode == 2'h2) |=> drive_output_enable)
    else $error("mode 10 not restored after 200 cycles");
  a_member_one: assert property (@(posedge hclk) disable iff (!hresetn)
    (group_member_select == 2'h1) |-> group_enable == 3'h1)
    else $error("member select 01 not first only");
  a_bus_irq0: assert property (@(posedge hclk) disable iff (!hresetn)
    (ctrl.ext_irq_zero_source == cocp_pkg::SRC_BUS &&
    (ctrl.ext_irq_zero_edge ? $fell(bus_sync) : $rose(bus_sync))) |=> ext_irq_zero)
    else $error("bus comparator not routed to irq zero");
  a_neutral_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    (group_mode == 2'h1) |-> group_neg_neutral && !group_neg_shared_pin)
    else $error("neutral mode routing wrong");
  c_trip: cover property (@(posedge hclk) disable iff (!hresetn) state == COCP_TRIP);
  c_auto_restore: cover property (@(posedge hclk) disable iff (!hresetn)
    state == COCP_WAIT ##1 state == COCP_RUN);
  c_window: cover property (@(posedge hclk) disable iff (!hresetn) $rose(window));
endmodule

//--- verification/cocp_drive_model.sv
// Drive timer and PWM stage model facing the protection block
`timescale 1ns/1ps
module cocp_drive_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wrap_en,
  output logic pwm,
  output logic timer_wrap
);
  // ********
  // Drive timer
  // ********
  logic [5:0] cnt;
  // Free running count, PWM is its top bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 6'h00;
    end else begin
      cnt <= cnt + 6'h01;
    end
  end
  assign pwm = cnt[5];
  // Wrap pulse gated so the fixed restore delay can be seen alone
  assign timer_wrap = wrap_en && (cnt == 6'h3F);
endmodule

//--- verification/testbench.sv
// Self-checking bench for the comparator protection block
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((e) !== (s)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module testbench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ocp = 0, bus = 0, wrap_en = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
  logic [1:0] htrans = 0, imode;
  logic [2:0] hsize = 3'h2, graw = 0, gen, cap;
  logic hrdy, pwm, twrap, doe, req, eirq, gshr, gneu, gsep, galt, dbg, con, hon, bon, hresp, alt;
  logic [2:0] ng [4] = '{3'h4, 3'h2, 3'h1, 3'h4};
  int fails = 0, comparisons = 0, cyc = 0, n, lat [4], fw [4] = '{0, 6, 12, 24};
  cocp_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
    .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .ocp_comparator_out(ocp),
    .bus_comparator_out(bus), .group_raw(graw), .ext_irq_zero_pin(1'b0), .pwm(pwm),
    .timer_wrap(twrap), .ocp_comparator_on(con), .ocp_hysteresis_on(hon),
    .ocp_input_mode(imode), .bus_comparator_on(bon), .group_enable(gen),
    .group_neg_shared_pin(gshr), .group_neg_neutral(gneu), .group_neg_separate(gsep),
    .group_pos_alternate(galt), .drive_output_enable(doe), .ocp_request(req),
    .ext_irq_zero(eirq), .capture_out(cap), .debug_pin(dbg), .alternate_pin(alt));
  cocp_drive_model u_drv (.hclk(hclk), .hresetn(hresetn), .wrap_en(wrap_en), .pwm(pwm),
    .timer_wrap(twrap));
  // Clock and hang guard
  always #25 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end
  // Each phase held until ready is seen high at a rising edge; one idle edge lets writes settle
  task automatic bx(input logic [7:0] a, input logic w, input logic [31:0] v);
    @(posedge hclk);
    haddr <= {24'h0, a}; hwrite <= w; htrans <= 2'h2; hsel <= 1'b1;
    do @(posedge hclk); while (hrdy !== 1'b1);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= v;
    do @(posedge hclk); while (hrdy !== 1'b1);
    d = hrdata;
    @(posedge hclk);
  endtask
  task automatic tk(input int k);
    repeat (k) @(posedge hclk);
  endtask
  // Raise the trip input and count cycles up to the request
  task automatic ev(output int k);
    @(posedge hclk);
    ocp <= 1'b1;
    k = 0;
    do begin @(negedge hclk); k++; end while (req !== 1'b1 && k < 100);
    @(posedge hclk);
    ocp <= 1'b0;
  endtask
  task automatic stop_test();
    $display("counts: comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ********
  // Test sequence
  // ********
  initial begin
    tk(10);
    hresetn <= 1'b1;
    bx(cocp_pkg::CTRL_OFS, 0, 0); `CHK("ctrl", cocp_pkg::CTRL_RST, d)
    bx(cocp_pkg::SAMPLE_OFS, 0, 0); `CHK("sample", cocp_pkg::SAMPLE_RST, d)
    bx(8'h10, 0, 0); `CHK("unmapped", 32'h0, d)
    bx(cocp_pkg::STATUS_OFS, 0, 0); `CHK("st_doe", 1'b1, d[2])
    `CHK("resp", 1'b0, hresp)
    $display("test reset done");
    bx(cocp_pkg::CTRL_OFS, 1, 32'h83C); `CHK("cfg", 5'h17, {imode, con, hon, bon})
    bx(cocp_pkg::CTRL_OFS, 1, 32'h24); `CHK("cfg", 5'h0A, {imode, con, hon, bon})
    bx(cocp_pkg::CTRL_OFS, 1, 32'h10); `CHK("cfg", 5'h04, {imode, con, hon, bon})
    // Same trip under each filter code, drive must stay on in mode 00
    for (int f = 0; f < 4; f++) begin
      bx(cocp_pkg::CTRL_OFS, 1, 32'h13 | (f << 9));
      ev(lat[f]); `CHK("doe_m0", 1'b1, doe)
      tk(40);
    end
    for (int f = 1; f < 4; f++) `CHK("filter", fw[f], lat[f] - lat[0])
    `CHK("sync", 1'b1, lat[0] > 2)
    $display("test filter done");
    bx(cocp_pkg::CTRL_OFS, 1, 32'h53);
    ev(n); `CHK("doe_m1", 1'b0, doe)
    tk(300); @(negedge hclk); `CHK("doe_hold", 1'b0, doe)
    bx(cocp_pkg::CTRL_OFS, 1, 32'h10053); tk(1); `CHK("rearm", 1'b1, doe)
    // Timed restore for modes 10 and 11, then early restore on a timer wrap
    for (int m = 2; m < 5; m++) begin
      wrap_en <= (m == 4);
      bx(cocp_pkg::CTRL_OFS, 1, 32'h13 | ((m == 4 ? 2 : m) << 6));
      ev(n); `CHK("doe_off", 1'b0, doe)
      n = 0;
      do begin @(negedge hclk); n++; end while (doe !== 1'b1 && n < 400);
      `CHK("restore", 1'b1, m == 4 ? n <= 66 : n == 400 - 100 * m)
    end
    $display("test protect done");
    // Bus trip via irq zero: mode 00 keeps drive, mode 01 with select clears it
    for (int i = 0; i < 2; i++) begin
      bx(cocp_pkg::CTRL_OFS, 1, i ? 32'hF940 : 32'hF800);
      bus <= 1'b1;
      tk(6);
      bx(cocp_pkg::STATUS_OFS, 0, 0); `CHK("bus_rd", 1'b1, d[1])
      bus <= 1'b0;
      n = 0;
      do begin @(negedge hclk); n++; end while (eirq !== 1'b1 && n < 20);
      `CHK("irq0", 1'b1, eirq)
      tk(3); @(negedge hclk); `CHK("doe_irq0", i == 0, doe)
      bx(cocp_pkg::CTRL_OFS, 1, 32'h10000);
    end
    $display("test irq zero done");
    for (int m = 0; m < 4; m++) for (int s = 0; s < 4; s++) begin
      bx(cocp_pkg::GROUP_OFS, 1, m | (s << 2) | (s[0] << 4));
      `CHK("gen", s == 0 ? (m == 3 ? 3'h3 : 3'h7) : (m == 3 && s == 3) ? 3'h0 : 3'h1 << (s - 1), gen)
      `CHK("gneg", ng[m], {gshr, gneu, gsep})
      if (m == 1) `CHK("galt", s[0], galt)
    end
    $display("test group done");
    bx(cocp_pkg::CTRL_OFS, 1, 32'h10);
    bx(cocp_pkg::GROUP_OFS, 1, 32'h310);
    bx(cocp_pkg::SAMPLE_OFS, 1, 32'h0);
    graw <= 3'h7;
    ocp <= 1'b1;
    tk(10); @(negedge hclk); `CHK("capture", 3'h7, cap)
    `CHK("debug", 1'b1, dbg)
    `CHK("alt", 1'b1, alt)
    // Window of on-delay 4, off-lead 2 over two 64-cycle PWM periods, high half 32
    bx(cocp_pkg::SAMPLE_OFS, 1, 32'h10204);
    tk(70); n = 0;
    repeat (128) begin @(negedge hclk); n += u_dut.window; end
    `CHK("window", 60, n)
    $display("test output done");
    stop_test();
  end
endmodule
